// ==== scp_clock_prescaler.sv ====
// System clock prescaler with oscillator trim register, Avalon-MM slave.
// Assumes fuse straps are static; factory trim is stable around reset.
//
// Notes on behaviour
// - Divided enable drives CPU, flash, I/O and ADC domains alike.
// - Works from any master clock source feeding mclk.
// - Setting changes never create glitches or runt periods.
// - No intermediate period shorter than both old and new periods.
// - Synchronous counter on undivided clock; count is never readable.
// - New rate active from the first old period end after the write.
// - Enable bit arms only when the same write clears all other bits.
// - Enable self-clears after four divided clock cycles or on a select write.
// - Rewriting enable while armed neither restarts window nor clears it.
// - Codes 0 to 8 divide by 1 to 256; higher codes reserved.
// - Reset loads select 0, or 3 when the divide-by-eight fuse is set.
// - Guarded sequence accepts any select code regardless of the fuse.
// - Reset loads the factory trim value into the trim register.
// - Software trim write reaches the oscillator at once.
// - Trim bit 7 picks low or high overlapping range.
// - Trim bits 6 to 0 tune monotonically within the range.
// - Clock output pin carries the divided clock, not the source.
`timescale 1ns/1ps
module scp_clock_prescaler (
  input  wire logic                          mclk,                // Undivided master clock
  input  wire logic                          resetn,              // Sync reset, active low
  input  wire logic [scp_pkg::SCP_ADDR_W-1:0] avs_address,        // Byte address
  input  wire logic                          avs_read,            // Read request
  input  wire logic                          avs_write,           // Write request
  input  wire logic [31:0]                   avs_writedata,       // Write data
  input  wire logic [3:0]                    avs_byteenable,      // Byte lanes
  output      logic [31:0]                   avs_readdata,        // Read data
  output      logic                          avs_waitrequest,     // Stall, active high
  input  wire logic                          initial_divide_by_eight_fuse, // Fuse pin
  input  wire logic                          clock_output_fuse,   // Clock pin enable strap
  input  wire logic [7:0]                    factory_trim,        // Calibration byte
  output      logic                          cpu_clk_en,          // CPU clock enable
  output      logic                          flash_clk_en,        // Flash clock enable
  output      logic                          io_clk_en,           // I/O clock enable
  output      logic                          adc_clk_en,          // ADC clock enable
  output      logic                          clock_output_pin,    // Divided clock level
  output      logic                          clock_output_pin_oe, // Pin driven when high
  output      logic [7:0]                    rc_oscillator_trim,  // Trim to oscillator
  output      logic                          trim_range_select,   // Range bit
  output      logic [6:0]                    trim_tune            // Fine tune bits
);
  import scp_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  scp_div_if   div_if ();

  logic        waitrequest_q;
  logic [31:0] readdata_q;
  logic [31:0] readdata_d;
  logic        fuse_s1_q;
  logic        fuse_s2_q;
  logic        fuse_s3_q;
  logic        strap_pend_q;
  logic [1:0]  strap_cnt_q;
  logic        pin_en_q;
  logic [3:0]  select_q;
  logic [7:0]  trim_q;
  scp_arm_t    arm_q;
  scp_arm_t    arm_d;
  logic [2:0]  arm_cnt_q;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  // Request taken only in the cycle the stall is low
  wire       bus_req   = avs_read | avs_write;
  wire       bus_take  = bus_req & ~waitrequest_q;
  wire       hit_ctrl  = (avs_address == SCP_ADDR_DIV_CTRL);
  wire       hit_trim  = (avs_address == SCP_ADDR_TRIM);
  wire [7:0] wd        = avs_writedata[7:0];
  wire       lane0     = avs_byteenable[0];
  wire       wr_ctrl   = bus_take & avs_write & hit_ctrl & lane0;
  wire       wr_trim   = bus_take & avs_write & hit_trim & lane0;
  wire       armed     = (arm_q == SCP_ST_ARMED);
  wire [7:0] ctrl_view = {armed, 3'h0, select_q};

  // Unmapped reads return zero, unmapped writes are dropped
  assign readdata_d = hit_ctrl ? {24'h000000, ctrl_view} :
                      hit_trim ? {24'h000000, trim_q} : 32'h00000000;

  // One stall cycle per access, read data set up with it
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      waitrequest_q <= 1'b1;
      readdata_q    <= 32'h00000000;
    end else begin
      waitrequest_q <= ~(bus_req & waitrequest_q);
      if (bus_req && waitrequest_q) begin
        readdata_q <= readdata_d;
      end
    end
  end

  // ---------------------------------------------------------------
  // Fuse capture after reset release
  // ---------------------------------------------------------------
  // Three stages; only the last two are compared
  always_ff @(posedge mclk) begin
    fuse_s1_q <= initial_divide_by_eight_fuse;
    fuse_s2_q <= fuse_s1_q;
    fuse_s3_q <= fuse_s2_q;
  end

  wire strap_load = strap_pend_q && (strap_cnt_q == SCP_STRAP_CYCLES) &&
                    (fuse_s2_q == fuse_s3_q);

  // Straps are taken after release so reset loads only constants
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      strap_pend_q <= 1'b1;
      strap_cnt_q  <= 2'h0;
      pin_en_q     <= 1'b0;
    end else if (strap_pend_q) begin
      if (strap_cnt_q != SCP_STRAP_CYCLES) begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
      end
      if (strap_load) begin
        strap_pend_q <= 1'b0;
        pin_en_q     <= clock_output_fuse;
      end
    end
  end

  // ---------------------------------------------------------------
  // Guarded change sequence
  // ---------------------------------------------------------------
  // Arm only on an exact 0x80; window counted in divided cycles
  wire arm_set = !armed && wr_ctrl && (wd == SCP_ARM_VALUE) && !strap_pend_q;
  wire sel_wr  = armed && wr_ctrl && !wd[SCP_CE_BIT];
  wire timeout = armed && div_if.tick && (arm_cnt_q == SCP_ARM_WINDOW - 3'h1);

  always_comb begin
    arm_d = arm_q;
    case (arm_q)
      SCP_ST_IDLE: begin
        if (arm_set) begin
          arm_d = SCP_ST_ARMED;
        end
      end
      SCP_ST_ARMED: begin
        // A repeated 0x80 falls through untouched
        if (sel_wr || timeout) begin
          arm_d = SCP_ST_IDLE;
        end
      end
      default: arm_d = SCP_ST_IDLE;
    endcase
  end

  // Window counter starts at arming and never restarts while armed
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      arm_q     <= SCP_ST_IDLE;
      arm_cnt_q <= 3'h0;
    end else begin
      arm_q <= arm_d;
      if (arm_set) begin
        arm_cnt_q <= 3'h0;
      end else if (armed && div_if.tick) begin
        arm_cnt_q <= arm_cnt_q + 3'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Select and trim registers
  // ---------------------------------------------------------------
  // Any code is stored; the core skips reserved ones
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      select_q <= SCP_SEL_RESET;
      trim_q   <= SCP_TRIM_RESET;
    end else begin
      if (strap_load) begin
        select_q <= fuse_s3_q ? SCP_SEL_FUSED : SCP_SEL_RESET;
        trim_q   <= factory_trim;
      end else if (sel_wr) begin
        select_q <= wd[SCP_SEL_W-1:0];
      end
      if (wr_trim && !strap_load) begin
        trim_q <= wd;
      end
    end
  end

  // ---------------------------------------------------------------
  // Divider core and outputs
  // ---------------------------------------------------------------
  // Divider ticks held off until the straps are in, so no early fast ticks
  assign div_if.req_sel = select_q;
  assign div_if.hold    = strap_pend_q;

  scp_div_core u_core (
    .mclk   (mclk),
    .resetn (resetn),
    .dif    (div_if.core)
  );

  // mclk is whatever source was picked upstream
  assign cpu_clk_en          = div_if.tick;
  assign flash_clk_en        = div_if.tick;
  assign io_clk_en           = div_if.tick;
  assign adc_clk_en          = div_if.tick;
  assign clock_output_pin    = div_if.phase;
  assign clock_output_pin_oe = pin_en_q;
  assign rc_oscillator_trim  = trim_q;
  assign trim_range_select   = trim_q[7];
  assign trim_tune           = trim_q[6:0];
  assign avs_readdata        = readdata_q;
  assign avs_waitrequest     = waitrequest_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_arm_exact;
    $rose(armed) |-> $past(wr_ctrl && (wd == SCP_ARM_VALUE));
  endproperty
  a_arm_exact: assert property (p_arm_exact)
    else $error("armed without an exact arming write");

  property p_arm_expires;
    (armed && div_if.tick && (arm_cnt_q == SCP_ARM_WINDOW - 3'h1)) |=> !armed;
  endproperty
  a_arm_expires: assert property (p_arm_expires)
    else $error("arming outlived its window");

  property p_rearm_keeps;
    (armed && wr_ctrl && (wd == SCP_ARM_VALUE) && !timeout)
      |=> (armed && (arm_cnt_q != 3'h0 || $past(arm_cnt_q) == 3'h0));
  endproperty
  a_rearm_keeps: assert property (p_rearm_keeps)
    else $error("repeat arming cleared or restarted window");

  property p_sel_guarded;
    ($changed(select_q) && !$past(strap_pend_q)) |-> $past(armed && wr_ctrl);
  endproperty
  a_sel_guarded: assert property (p_sel_guarded)
    else $error("select changed outside the window");

  property p_sel_taken;
    sel_wr |=> ((select_q == $past(wd[3:0])) && !armed);
  endproperty
  a_sel_taken: assert property (p_sel_taken)
    else $error("select write not stored");

  property p_strap_value;
    $fell(strap_pend_q) |->
      ((select_q == ($past(fuse_s3_q) ? SCP_SEL_FUSED : SCP_SEL_RESET)) &&
       (trim_q == $past(factory_trim)));
  endproperty
  a_strap_value: assert property (p_strap_value)
    else $error("wrong select or trim after reset");

  property p_trim_write;
    (wr_trim && !strap_pend_q) |=> (rc_oscillator_trim == $past(wd));
  endproperty
  a_trim_write: assert property (p_trim_write)
    else $error("trim write did not reach oscillator");

  property p_domains_equal;
    (cpu_clk_en == io_clk_en) && (flash_clk_en == adc_clk_en) && (cpu_clk_en == adc_clk_en);
  endproperty
  a_domains_equal: assert property (p_domains_equal)
    else $error("clock domains disagree");

  // Pin enable is the strap captured with the other straps
  property p_pin_enable;
    $fell(strap_pend_q) |-> (clock_output_pin_oe == $past(clock_output_fuse));
  endproperty
  a_pin_enable: assert property (p_pin_enable)
    else $error("pin enable differs from its strap");

  // Divider gives no ticks until the straps are in
  property p_quiet_in_hold;
    strap_pend_q |-> !cpu_clk_en;
  endproperty
  a_quiet_in_hold: assert property (p_quiet_in_hold)
    else $error("tick while straps pending");

  // Window count only moves forward while armed
  property p_cnt_forward;
    armed |=> (!armed || (arm_cnt_q >= $past(arm_cnt_q)));
  endproperty
  a_cnt_forward: assert property (p_cnt_forward)
    else $error("arming window count went back");

  property p_bus_answer;
    (bus_req && waitrequest_q) |=> (!avs_waitrequest ##1 avs_waitrequest);
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer not after one stall");

  c_full_change: cover property (arm_set ##[1:8] sel_wr);
  c_timeout:     cover property (timeout);
  c_trim:        cover property (wr_trim && !strap_pend_q);
endmodule

// ==== scp_pkg.sv ====
// Shared constants and helpers for the system clock prescaler.
// Assumes one master clock; all slower rates are one-cycle enables.
package scp_pkg;

  // ---------------------------------------------------------------
  // Register map (index form, byte address is four times the index)
  // ---------------------------------------------------------------
  localparam int          SCP_ADDR_W        = 10;
  localparam logic [7:0]  SCP_IDX_DIV_CTRL  = 8'h61;
  localparam logic [7:0]  SCP_IDX_TRIM      = 8'h66;
  localparam logic [9:0]  SCP_ADDR_DIV_CTRL = {SCP_IDX_DIV_CTRL, 2'b00};
  localparam logic [9:0]  SCP_ADDR_TRIM     = {SCP_IDX_TRIM, 2'b00};

  // ---------------------------------------------------------------
  // Field layout and reset values
  // ---------------------------------------------------------------
  localparam int          SCP_CE_BIT        = 7;
  localparam int          SCP_SEL_W         = 4;
  localparam logic [7:0]  SCP_ARM_VALUE     = 8'h80;
  localparam logic [3:0]  SCP_SEL_MAX       = 4'h8;
  localparam logic [3:0]  SCP_SEL_RESET     = 4'h0;
  localparam logic [3:0]  SCP_SEL_FUSED     = 4'h3;
  localparam logic [7:0]  SCP_TRIM_RESET    = 8'h00;
  localparam int          SCP_CNT_W         = 8;

  // ---------------------------------------------------------------
  // Cycle counts
  // ---------------------------------------------------------------
  localparam logic [2:0]  SCP_ARM_WINDOW    = 3'h4;
  localparam logic [1:0]  SCP_STRAP_CYCLES  = 2'h3;

  // Guarded change sequence states
  typedef enum logic {SCP_ST_IDLE, SCP_ST_ARMED} scp_arm_t;

  // Period of a select code in master clock cycles
  function automatic logic [8:0] scp_period(input logic [3:0] sel);
    scp_period = 9'h001 << sel;
  endfunction

  // Low count bits that must all be set at the end of a period
  function automatic logic [7:0] scp_mask(input logic [3:0] sel);
    logic [8:0] t;
    t = scp_period(sel) - 9'h001;
    scp_mask = t[7:0];
  endfunction

  // Count bit that marks the second half of a period
  function automatic logic [7:0] scp_half(input logic [3:0] sel);
    logic [8:0] t;
    t = scp_period(sel);
    scp_half = (sel == 4'h0) ? 8'h00 : t[8:1];
  endfunction

endpackage

// ==== scp_div_if.sv ====
// Carrier between the prescaler register logic and its divider core.
// Assumes both ends run on the same master clock.
`timescale 1ns/1ps
interface scp_div_if;
  logic [3:0] req_sel;  // Requested select code
  logic       hold;     // Hold off divider ticks
  logic       tick;     // Divided clock enable
  logic       phase;    // Divided clock level

  modport core (input req_sel, input hold, output tick, output phase);
  modport ctrl (output req_sel, output hold, input tick, input phase);
endinterface

// ==== scp_div_core.sv ====
// Divider core: counter on the undivided clock cleared at each period end, glitch-free switch.
// Assumes req_sel is a register on the same clock; reserved codes are ignored.
`timescale 1ns/1ps
module scp_div_core (
  input wire logic mclk,    // Undivided master clock
  input wire logic resetn,  // Synchronous reset, active low
  scp_div_if.core  dif      // Select in, enables out
);
  import scp_pkg::*;

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [3:0] act_sel_q;
  logic [3:0] next_sel;
  logic       tick_q;
  logic       phase_q;
  logic       phase_d;
  logic       wrap;

  // ---------------------------------------------------------------
  // Period boundary and select hand-over
  // ---------------------------------------------------------------
  // New code only taken at a boundary, so no short period appears
  assign wrap     = ((cnt_q & scp_mask(act_sel_q)) == scp_mask(act_sel_q)) && !dif.hold;
  assign next_sel = (wrap && (dif.req_sel <= SCP_SEL_MAX)) ? dif.req_sel : act_sel_q;
  assign cnt_d    = wrap ? 8'h00 : cnt_q + 8'h01;
  assign phase_d  = (next_sel == 4'h0) ? ~phase_q : ((cnt_d & scp_half(next_sel)) == 8'h00);

  // Counter state is kept internal, only the enable and the phase level leave
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cnt_q     <= 8'h00;
      act_sel_q <= SCP_SEL_RESET;
      tick_q    <= 1'b0;
      phase_q   <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      act_sel_q <= next_sel;
      tick_q    <= wrap;
      phase_q   <= phase_d;
    end
  end

  assign dif.tick  = tick_q;
  assign dif.phase = phase_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [8:0] gap_q;
  logic [8:0] per_q;
  logic       seen_q;

  // Cycles since the last tick and the period it promised
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      gap_q  <= 9'h000;
      per_q  <= 9'h000;
      seen_q <= 1'b0;
    end else begin
      gap_q  <= tick_q ? 9'h001 : gap_q + 9'h001;
      per_q  <= tick_q ? scp_period(act_sel_q) : per_q;
      seen_q <= seen_q | tick_q;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_period_exact;
    (seen_q && tick_q && !$past(dif.hold)) |-> (gap_q == per_q);
  endproperty
  a_period_exact: assert property (p_period_exact)
    else $error("divided period differs from its setting");

  property p_sel_at_boundary;
    $changed(act_sel_q) |-> tick_q;
  endproperty
  a_sel_at_boundary: assert property (p_sel_at_boundary)
    else $error("division changed inside a period");

  property p_two_edges;
    (tick_q && $changed(act_sel_q)) |-> ##[1:256] tick_q;
  endproperty
  a_two_edges: assert property (p_two_edges)
    else $error("no second edge after switch");

  c_switch: cover property ($changed(act_sel_q));
  c_div256: cover property (tick_q && act_sel_q == SCP_SEL_MAX);
endmodule

// ==== scp_clock_prescaler_tb.sv ====
// Self-checking testbench for the system clock prescaler and trim register.
// Assumes scp_pkg and the design files are compiled first; single mclk domain.
`timescale 1ns/1ps
module scp_clock_prescaler_tb;
  import scp_pkg::*;

  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic        mclk;
  logic        resetn;
  logic [9:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        div8_fuse;
  logic        clk_out_fuse;
  logic [7:0]  factory_trim;
  logic        cpu_en;
  logic        flash_en;
  logic        io_en;
  logic        adc_en;
  logic        pin_level;
  logic        pin_oe;
  logic [7:0]  trim;
  logic        range_sel;
  logic [6:0]  tune;
  logic [31:0] q;
  int          miscompares;
  int          tests_run;
  int          cycles;
  int          per;
  int          gap;
  int          hi;

  scp_clock_prescaler scp_clock_prescaler_i (
    .mclk                         (mclk),
    .resetn                       (resetn),
    .avs_address                  (avs_address),
    .avs_read                     (avs_read),
    .avs_write                    (avs_write),
    .avs_writedata                (avs_writedata),
    .avs_byteenable               (avs_byteenable),
    .avs_readdata                 (avs_readdata),
    .avs_waitrequest              (avs_waitrequest),
    .initial_divide_by_eight_fuse (div8_fuse),
    .clock_output_fuse            (clk_out_fuse),
    .factory_trim                 (factory_trim),
    .cpu_clk_en                   (cpu_en),
    .flash_clk_en                 (flash_en),
    .io_clk_en                    (io_en),
    .adc_clk_en                   (adc_en),
    .clock_output_pin             (pin_level),
    .clock_output_pin_oe          (pin_oe),
    .rc_oscillator_trim           (trim),
    .trim_range_select            (range_sel),
    .trim_tune                    (tune)
  );

  // ---------------------------------------------------------------
  // Clock and hang guard
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Ceiling well above the longest run of 256-cycle periods
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      conclude();
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Called just after a rising edge; request is left up for chaining
  task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d,
                      input logic [3:0] be, output logic [31:0] rd);
    int n;
    avs_address    <= a;
    avs_writedata  <= {24'h000000, d};
    avs_byteenable <= be;
    avs_read       <= ~w;
    avs_write      <= w;
    n = 0;
    // Answer and read data are taken at the rising edge that sees the stall low
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (avs_waitrequest !== 1'b0) miscompares++;
    rd = avs_readdata;
  endtask

  task automatic idle();
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask

  // Guarded two-step change, second write presented back to back
  task automatic change(input logic [3:0] s);
    xfer(1'b1, SCP_ADDR_DIV_CTRL, SCP_ARM_VALUE, 4'hF, q);
    xfer(1'b1, SCP_ADDR_DIV_CTRL, {4'h0, s}, 4'hF, q);
    idle();
  endtask

  // Three tick intervals; gap is the second, per the third, hi its pin-high cycles
  task automatic measure();
    int n;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      hi = 0;
      do begin
        @(negedge mclk);
        n++;
        hi += pin_level;
      end while (cpu_en !== 1'b1 && n < 1000);
      gap = per;
      per = n;
    end
    check("domain enables", {flash_en, io_en, adc_en}, 32'h7);
    @(posedge mclk);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    resetn = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 10'h000;
    avs_writedata = 32'h00000000; avs_byteenable = 4'hF; div8_fuse = 1'b1;
    clk_out_fuse = 1'b1; factory_trim = 8'hA5; miscompares = 0; tests_run = 0;
    cycles = 0; per = 0; gap = 0; hi = 0;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    // Straps load a few cycles after release
    repeat (8) @(posedge mclk);
    xfer(1'b0, SCP_ADDR_DIV_CTRL, 8'h00, 4'hF, q);
    check("select after reset", q, 32'h3);
    xfer(1'b0, SCP_ADDR_TRIM, 8'h00, 4'hF, q);
    check("trim after reset", q, 32'hA5);
    idle();
    check("pin enable", {31'h0, pin_oe}, 32'h1);
    $display("test reset values done");

    // Trim writes reach the oscillator outputs; lane 0 off drops the write
    xfer(1'b1, SCP_ADDR_TRIM, 8'h7F, 4'hF, q);
    idle();
    check("trim 7F", {23'h0, range_sel, trim}, 32'h07F);
    check("tune 7F", {25'h0, tune}, 32'h7F);
    xfer(1'b1, SCP_ADDR_TRIM, 8'h80, 4'hF, q);
    xfer(1'b1, SCP_ADDR_TRIM, 8'h11, 4'hE, q);
    xfer(1'b0, SCP_ADDR_TRIM, 8'h00, 4'hF, q);
    idle();
    check("trim 80", q, 32'h80);
    check("range high", {24'h0, range_sel, tune}, 32'h80);
    $display("test trim done");

    // Unmapped place and refused writes leave the select alone
    xfer(1'b0, 10'h000, 8'h00, 4'hF, q);
    check("unmapped read", q, 32'h0);
    xfer(1'b1, 10'h188, 8'h80, 4'hF, q);
    xfer(1'b1, SCP_ADDR_DIV_CTRL, 8'h81, 4'hF, q);
    xfer(1'b1, SCP_ADDR_DIV_CTRL, 8'h05, 4'hF, q);
    xfer(1'b0, SCP_ADDR_DIV_CTRL, 8'h00, 4'hF, q);
    idle();
    check("refused writes", q, 32'h3);
    $display("test refused writes done");

    // Every legal code, from the fused start value
    for (int s = 0; s <= 8; s++) begin
      change(s[3:0]);
      xfer(1'b0, SCP_ADDR_DIV_CTRL, 8'h00, 4'hF, q);
      idle();
      check("select readback", q, s);
      measure();
      check("tick period", per, 1 << s);
      check("no short period", gap >= ((s == 0) ? 1 : (1 << (s - 1))), 1);
      if (s > 0) check("pin high half", hi, 1 << (s - 1));
    end
    // Reserved code is stored but the factor stays
    change(4'h9);
    xfer(1'b0, SCP_ADDR_DIV_CTRL, 8'h00, 4'hF, q);
    idle();
    check("reserved readback", q, 32'h9);
    measure();
    check("reserved keeps rate", per, 256);
    change(4'h0);
    // Wait out the old 256-cycle period so the window test runs at divide by one
    measure();
    check("back to one", per, 1);
    $display("test division codes done");

    // Window lapses after four ticks at divide by one
    xfer(1'b1, SCP_ADDR_DIV_CTRL, 8'h80, 4'hF, q);
    idle();
    repeat (10) @(posedge mclk);
    xfer(1'b1, SCP_ADDR_DIV_CTRL, 8'h02, 4'hF, q);
    xfer(1'b0, SCP_ADDR_DIV_CTRL, 8'h00, 4'hF, q);
    idle();
    check("late select", q, 32'h0);

    // Re-arming neither clears nor restarts the window (32 cycles at /8)
    change(4'h3);
    xfer(1'b1, SCP_ADDR_DIV_CTRL, 8'h80, 4'hF, q);
    idle();
    repeat (17) @(posedge mclk);
    xfer(1'b1, SCP_ADDR_DIV_CTRL, 8'h80, 4'hF, q);
    xfer(1'b0, SCP_ADDR_DIV_CTRL, 8'h00, 4'hF, q);
    check("still armed", q, 32'h83);
    idle();
    repeat (14) @(posedge mclk);
    xfer(1'b0, SCP_ADDR_DIV_CTRL, 8'h00, 4'hF, q);
    idle();
    check("window not restarted", q, 32'h3);
    $display("test window done");

    // Second reset mid-run with the fuse clear
    resetn       <= 1'b0;
    div8_fuse    <= 1'b0;
    factory_trim <= 8'h3C;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    repeat (8) @(posedge mclk);
    xfer(1'b0, SCP_ADDR_DIV_CTRL, 8'h00, 4'hF, q);
    check("select unfused", q, 32'h0);
    xfer(1'b0, SCP_ADDR_TRIM, 8'h00, 4'hF, q);
    check("trim reload", q, 32'h3C);
    idle();
    $display("test second reset done");
    conclude();
  end
endmodule
